// ### design/store_params.svh
// constants for the storage unit: field layout, reset values and timing counts
`ifndef STORE_PARAMS_SVH
`define STORE_PARAMS_SVH

`define WORD_W              68
`define DATA_W              60
`define ECC_W               8
`define ADDR_W              14
`define BANKS               8
`define BANK_W              3
`define QUAD_W              2
`define QUAD_LSB            12
`define CHIP_W              2
`define CHIP_LSB            10
`define CELL_W              10
`define IDX_W               17
`define ROW_W               7
`define CNT_W               6
`define GAP_W               11

`define UNIT_ID_DEFAULT     1'b0
`define ROW_RESET           7'h00
`define ONES_WORD           {`WORD_W{1'b1}}

`define CLK_PERIOD_NS       8
`define BANK_CYCLE_NS       400
`define BANK_CYCLE_CYC      ((`BANK_CYCLE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define REFRESH_CYCLE_NS    400
`define REFRESH_CYCLE_CYC   (`REFRESH_CYCLE_NS / `CLK_PERIOD_NS)
`define REFRESH_MIN_GAP_NS  12800
`define REFRESH_MIN_GAP_CYC ((`REFRESH_MIN_GAP_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// ### design/store_pkg.sv
// types shared by the storage unit
package store_pkg;
`include "store_params.svh"

    typedef logic [`WORD_W-1:0] word_t;
    typedef logic [`ADDR_W-1:0] store_addr_t;
    typedef logic [`BANKS-1:0]  bank_vec_t;

    typedef enum logic [1:0]
    {
        RF_IDLE  = 2'b00,
        RF_CYCLE = 2'b01
    } refresh_state_t;

endpackage : store_pkg

// ### design/storage_unit.sv
// one storage unit of the main store: eight banks, refresh sequencing, fault lockout
`timescale 1ns/100ps
`include "store_params.svh"

module storage_unit
    import store_pkg::*;
(
    input  wire logic                  core_clk,        // 125 MHz core clock
    input  wire logic                  sys_rst,         // master clear, async high
    input  wire logic                  unit_select_bit, // which unit is addressed
    input  wire store_pkg::bank_vec_t  bank_go,         // per-bank go strobe
    input  wire logic                  write_en,        // high for a write reference
    input  wire store_pkg::store_addr_t store_addr,     // quad, chip column, cell
    input  wire logic                  addr_parity,     // odd parity over store_addr
    input  wire store_pkg::word_t      write_data,      // word to store
    input  wire logic                  refresh_go,      // refresh go strobe
    input  wire logic                  relock_en,       // reconfiguration switch on
    input  wire logic [1:0]            relock_quad,     // quadrant locked out
    output logic                       read_valid,      // data-out loaded, one cycle
    output store_pkg::word_t           read_data,       // shared data-out register
    output logic                       parity_error,    // address parity error pulse
    output logic                       unit_disabled,   // fault status, sticky
    output logic [`ROW_W-1:0]          refresh_row      // refresh address counter
);
    import store_pkg::*;

    localparam logic UNIT_ID = `UNIT_ID_DEFAULT;

    // full-size store; one word per bank, quadrant, column and cell
    word_t                mem [0:(1 << `IDX_W)-1];

    logic [`IDX_W-1:0]    hold_idx  [`BANKS];
    word_t                hold_data [`BANKS];
    logic                 hold_wr   [`BANKS];
    logic                 hold_bad  [`BANKS];
    logic [`CNT_W-1:0]    hold_cnt  [`BANKS];
    logic [`IDX_W-1:0]    next_hold_idx  [`BANKS];
    word_t                next_hold_data [`BANKS];
    logic                 next_hold_wr   [`BANKS];
    logic                 next_hold_bad  [`BANKS];
    logic [`CNT_W-1:0]    next_hold_cnt  [`BANKS];

    logic                 next_read_valid;
    word_t                next_read_data;
    logic                 next_parity_error;
    logic                 mem_we;
    logic [`IDX_W-1:0]    mem_idx;
    word_t                mem_wdata;
    bank_vec_t            take;
    logic                 par_ok;
    logic [2:0]           phys_quad;
    logic                 over_top;

    // address checks are common to all banks
    always_comb
    begin
        par_ok    = ^{store_addr, addr_parity};
        phys_quad = {1'b0, store_addr[`QUAD_LSB +: `QUAD_W]};
        // locking one quadrant shifts it and the ones above it up by one
        if (relock_en && store_addr[`QUAD_LSB +: `QUAD_W] >= relock_quad)
        begin
            phys_quad = phys_quad + 3'h1;
        end
        over_top = phys_quad[2];
        for (int b = 0; b < `BANKS; b++)
        begin
            take[b] = bank_go[b] && (unit_select_bit == UNIT_ID)
                      && (hold_cnt[b] == '0);
        end
    end

    always_comb
    begin
        next_read_valid   = 1'b0;
        next_read_data    = read_data;
        next_parity_error = (|take) && !par_ok;
        mem_we            = 1'b0;
        mem_idx           = '0;
        mem_wdata         = '0;
        for (int b = 0; b < `BANKS; b++)
        begin
            next_hold_idx[b]  = hold_idx[b];
            next_hold_data[b] = hold_data[b];
            next_hold_wr[b]   = hold_wr[b];
            next_hold_bad[b]  = hold_bad[b];
            next_hold_cnt[b]  = hold_cnt[b];
            if (take[b])
            begin
                // bank, quadrant, chip column, cell form the word index
                next_hold_idx[b]  = {`BANK_W'(b), phys_quad[1:0],
                                     store_addr[`CHIP_LSB +: `CHIP_W],
                                     store_addr[`CELL_W-1:0]};
                next_hold_data[b] = write_data;
                next_hold_wr[b]   = write_en;
                next_hold_bad[b]  = !par_ok || over_top || unit_disabled;
                next_hold_cnt[b]  = `CNT_W'(`BANK_CYCLE_CYC);
            end
            else if (hold_cnt[b] != '0)
            begin
                next_hold_cnt[b] = hold_cnt[b] - `CNT_W'(1);
            end
        end
        // controller spacing keeps completions apart; lowest bank wins a tie
        for (int b = `BANKS - 1; b >= 0; b--)
        begin
            if (hold_cnt[b] == `CNT_W'(1))
            begin
                mem_idx   = hold_idx[b];
                mem_wdata = hold_data[b];
                mem_we    = hold_wr[b] && !hold_bad[b] && !unit_disabled;
                if (!hold_wr[b])
                begin
                    next_read_valid = 1'b1;
                    next_read_data  = (hold_bad[b] || unit_disabled)
                                      ? `ONES_WORD : mem[hold_idx[b]];
                end
            end
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (mem_we)
        begin
            mem[mem_idx] <= mem_wdata;
        end
    end

    always_ff @(posedge core_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            read_valid   <= 1'b0;
            read_data    <= '0;
            parity_error <= 1'b0;
            for (int b = 0; b < `BANKS; b++)
            begin
                hold_idx[b]  <= '0;
                hold_data[b] <= '0;
                hold_wr[b]   <= 1'b0;
                hold_bad[b]  <= 1'b0;
                hold_cnt[b]  <= '0;
            end
        end
        else
        begin
            read_valid   <= next_read_valid;
            read_data    <= next_read_data;
            parity_error <= next_parity_error;
            hold_idx     <= next_hold_idx;
            hold_data    <= next_hold_data;
            hold_wr      <= next_hold_wr;
            hold_bad     <= next_hold_bad;
            hold_cnt     <= next_hold_cnt;
        end
    end

    // refresh sequencing and fault lockout
    refresh_state_t       rf_state;
    refresh_state_t       next_rf_state;
    logic [`CNT_W-1:0]    rf_cnt;
    logic [`CNT_W-1:0]    next_rf_cnt;
    logic [`GAP_W-1:0]    gap_cnt;
    logic [`GAP_W-1:0]    next_gap_cnt;
    logic [`ROW_W-1:0]    next_refresh_row;
    logic                 next_unit_disabled;
    logic                 rf_start;
    logic                 rf_fault;

    always_comb
    begin
        next_rf_state      = rf_state;
        next_rf_cnt        = rf_cnt;
        next_refresh_row   = refresh_row;
        next_unit_disabled = unit_disabled;
        rf_start           = 1'b0;
        rf_fault           = 1'b0;
        next_gap_cnt       = gap_cnt;
        if (gap_cnt < `GAP_W'(`REFRESH_MIN_GAP_CYC))
        begin
            next_gap_cnt = gap_cnt + `GAP_W'(1);
        end
        case (rf_state)
            RF_IDLE:
            begin
                // a disabled unit ignores refresh entirely
                if (refresh_go && !unit_disabled)
                begin
                    if (gap_cnt < `GAP_W'(`REFRESH_MIN_GAP_CYC))
                    begin
                        rf_fault = 1'b1;
                    end
                    else
                    begin
                        rf_start         = 1'b1;
                        next_rf_state    = RF_CYCLE;
                        next_rf_cnt      = `CNT_W'(`REFRESH_CYCLE_CYC);
                        next_gap_cnt     = '0;
                        next_refresh_row = refresh_row + `ROW_W'(1);
                    end
                end
            end
            RF_CYCLE:
            begin
                // refresh is an internal read; nothing reaches data-out
                next_rf_cnt = rf_cnt - `CNT_W'(1);
                if (rf_cnt == `CNT_W'(1))
                begin
                    next_rf_state = RF_IDLE;
                    rf_fault      = refresh_go; // strobe held a whole cycle
                end
            end
            default:
            begin
                next_rf_state = RF_IDLE;
            end
        endcase
        if (rf_fault)
        begin
            next_unit_disabled = 1'b1;
            next_rf_state      = RF_IDLE;
        end
    end

    // only master clear releases the lockout
    always_ff @(posedge core_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            rf_state      <= RF_IDLE;
            rf_cnt        <= '0;
            gap_cnt       <= `GAP_W'(`REFRESH_MIN_GAP_CYC);
            refresh_row   <= `ROW_RESET;
            unit_disabled <= 1'b0;
        end
        else
        begin
            rf_state      <= next_rf_state;
            rf_cnt        <= next_rf_cnt;
            gap_cnt       <= next_gap_cnt;
            refresh_row   <= next_refresh_row;
            unit_disabled <= next_unit_disabled;
        end
    end

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (sys_rst);
    a_par_flag: assert property ((|take) && !par_ok |=> parity_error)
        else $error("parity mismatch not flagged");
    a_disabled_ones: assert property (read_valid && unit_disabled |-> &read_data)
        else $error("disabled unit returned data");
    a_no_write_disabled: assert property (mem_we |-> !unit_disabled)
        else $error("write while disabled");
    a_bank_read_time: assert property (take[0] && !write_en |-> ##51 read_valid)
        else $error("bank read not returned after bank cycle");
    a_bad_par_read: assert property (take[0] && !write_en && !par_ok
        |-> ##51 (read_valid && (&read_data)))
        else $error("bad parity read not all ones");
    a_refresh_row: assert property (
        rf_start |=> refresh_row == $past(refresh_row) + 7'h01)
        else $error("refresh row did not step");
    a_disable_sticky: assert property (unit_disabled |=> unit_disabled)
        else $error("disable flop cleared without master clear");
    a_fault_gap: assert property (rf_state == RF_IDLE && refresh_go && !unit_disabled
        && gap_cnt < `GAP_W'(`REFRESH_MIN_GAP_CYC) |=> unit_disabled)
        else $error("early refresh not caught");
    a_relock_write: assert property (mem_we && relock_en
        |-> mem_idx[`IDX_W-`BANK_W-1 -: `QUAD_W] != relock_quad)
        else $error("write reached the locked-out quadrant");
    a_one_bank: assert property ($onehot0(take))
        else $error("more than one bank took a go");
    c_read: cover property (read_valid && !(&read_data));
    c_refresh: cover property (rf_start ##50 rf_state == RF_IDLE);
    c_fault: cover property (!unit_disabled ##1 unit_disabled);
endmodule : storage_unit

// ### test/ctrl_model.sv
// memory controller model: drives bank references and refresh strobes
`timescale 1ns/100ps
module ctrl_model
    import store_pkg::*;
(
    input  wire logic              core_clk,        // core clock
    output logic                   unit_select_bit, // unit addressed
    output store_pkg::bank_vec_t   bank_go,         // one-hot go strobe
    output logic                   write_en,        // write reference
    output store_pkg::store_addr_t store_addr,      // storage address
    output logic                   addr_parity,     // odd address parity
    output store_pkg::word_t       write_data,      // word to store
    output logic                   refresh_go       // refresh go strobe
);
    import store_pkg::*;

    initial
    begin
        unit_select_bit = 1'b0;
        bank_go = '0;
        write_en = 1'b0;
        store_addr = '0;
        addr_parity = 1'b1;
        write_data = '0;
        refresh_go = 1'b0;
    end

    // one reference; the caller spaces them, but the first write lands inside the first refresh cycle
    task automatic issue(input logic [2:0] bank, input logic unit, input logic wr,
                         input store_addr_t addr, input word_t data, input logic bad);
        @(posedge core_clk);
        unit_select_bit <= unit;
        bank_go <= bank_vec_t'(1) << bank;
        write_en <= wr;
        store_addr <= addr;
        addr_parity <= ~(^addr) ^ bad;
        write_data <= data;
        @(posedge core_clk);
        // released address, parity, data and write lines show the inverse, not a stale copy
        bank_go <= '0;
        store_addr <= ~addr;
        addr_parity <= (^addr) ^ bad;
        write_data <= ~data;
        write_en <= ~wr;
    endtask : issue

    // go strobe held for the given edges; no exchange jump here, so no wait
    task automatic refresh(input int hold);
        @(posedge core_clk);
        refresh_go <= 1'b1;
        repeat (hold) @(posedge core_clk);
        refresh_go <= 1'b0;
    endtask : refresh
endmodule : ctrl_model

// ### test/storage_unit_bench.sv
// self-checking bench for the storage unit
`timescale 1ns/100ps
module storage_unit_bench;
    import store_pkg::*;

    logic          core_clk;
    logic          sys_rst;
    logic          relock_en;
    logic [1:0]    relock_quad;
    logic          unit_select_bit;
    bank_vec_t     bank_go;
    logic          write_en;
    store_addr_t   store_addr;
    logic          addr_parity;
    word_t         write_data;
    logic          refresh_go;
    logic          read_valid;
    word_t         read_data;
    logic          parity_error;
    logic          unit_disabled;
    logic [6:0]    refresh_row;
    int            err_total;
    int            tests_run;
    int            seed;
    int            cycles;
    logic          dis_exp;
    store_addr_t   la;
    word_t         mem [logic [16:0]];

    storage_unit i_storage_unit (.core_clk(core_clk), .sys_rst(sys_rst),
        .unit_select_bit(unit_select_bit), .bank_go(bank_go), .write_en(write_en),
        .store_addr(store_addr), .addr_parity(addr_parity), .write_data(write_data),
        .refresh_go(refresh_go), .relock_en(relock_en), .relock_quad(relock_quad),
        .read_valid(read_valid), .read_data(read_data), .parity_error(parity_error),
        .unit_disabled(unit_disabled), .refresh_row(refresh_row));

    ctrl_model i_ctrl_model (.core_clk(core_clk), .unit_select_bit(unit_select_bit),
        .bank_go(bank_go), .write_en(write_en), .store_addr(store_addr),
        .addr_parity(addr_parity), .write_data(write_data), .refresh_go(refresh_go));

    initial
    begin
        core_clk = 1'b0;
        forever #4 core_clk = ~core_clk;
    end

    task automatic finish_test();
        if (err_total == 0 && tests_run > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : finish_test

    always @(posedge core_clk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            err_total++;
            finish_test();
        end
    end

    function automatic word_t rnd_word();
        return word_t'({$random(seed), $random(seed), $random(seed)});
    endfunction : rnd_word

    task automatic check(input string what, input word_t exp, input word_t got);
        tests_run++;
        if (got !== exp)
        begin
            err_total++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask : check

    // one reference with its expected outcome worked out from the address map
    task automatic access(input logic [2:0] bank, input logic wr, input store_addr_t a,
                          input word_t data, input logic bad, input logic unit);
        logic [2:0]  pq;
        store_addr_t pa;
        logic        refused;
        logic        seen_err;
        logic        seen_rd;
        word_t       exp;
        pq = {1'b0, a[13:12]} + ((relock_en && a[13:12] >= relock_quad) ? 3'd1 : 3'd0);
        pa = {pq[1:0], a[11:0]};
        refused = bad || pq[2] || dis_exp;
        exp = (refused || !mem.exists({bank, pa})) ? '1 : mem[{bank, pa}];
        seen_err = 1'b0;
        seen_rd = 1'b0;
        i_ctrl_model.issue(bank, unit, wr, a, data, bad);
        // parity_error stands only in the cycle after the take edge, so look before waiting
        for (int i = 0; i < 60 && !seen_rd; i++)
        begin
            #1;
            if (i < 3 && parity_error === 1'b1)
                seen_err = 1'b1;
            if (read_valid === 1'b1)
                seen_rd = 1'b1;
            else
                @(posedge core_clk);
        end
        if (!unit)
            check("parity_error", word_t'(bad), word_t'(seen_err));
        check("read_valid", word_t'(!wr && !unit), word_t'(seen_rd));
        if (seen_rd)
            check("read_data", exp, read_data);
        if (wr && !refused && !unit)
            mem[{bank, pa}] = data;
    endtask : access

    task automatic set_relock(input logic en, input logic [1:0] q);
        @(posedge core_clk);
        relock_en <= en;
        relock_quad <= q;
        #1;
    endtask : set_relock

    task automatic master_clear();
        @(posedge core_clk);
        sys_rst <= 1'b1;
        repeat (4) @(posedge core_clk);
        sys_rst <= 1'b0;
        @(posedge core_clk);
        #1;
        dis_exp = 1'b0;
        check("unit_disabled", '0, word_t'(unit_disabled));
        check("refresh_row", '0, word_t'(refresh_row));
    endtask : master_clear

    initial
    begin
        seed = 64750;
        err_total = 0;
        tests_run = 0;
        cycles = 0;
        dis_exp = 1'b0;
        sys_rst = 1'b1;
        relock_en = 1'b0;
        relock_quad = 2'($random(seed));
        repeat (4) @(posedge core_clk);
        master_clear();
        i_ctrl_model.refresh(1);
        #1;
        check("refresh_row", word_t'(1), word_t'(refresh_row));
        la = store_addr_t'($random(seed));
        for (int b = 0; b < 8; b++)
            access(3'(b), 1'b1, la, rnd_word(), 1'b0, 1'b0);
        for (int b = 7; b >= 0; b--)
            access(3'(b), 1'b0, la, '0, 1'b0, 1'b0);
        for (int q = 0; q < 16; q++)
            access(3'd0, 1'b1, {4'(q), la[9:0]}, rnd_word(), 1'b0, 1'b0);
        for (int q = 0; q < 16; q++)
            access(3'd0, 1'b0, {4'(q), la[9:0]}, '0, 1'b0, 1'b0);
        access(3'd0, 1'b1, la, word_t'($random(seed)), 1'b1, 1'b0);
        access(3'd0, 1'b0, la, '0, 1'b1, 1'b0);
        access(3'd0, 1'b0, la, '0, 1'b0, 1'b0);
        access(3'd3, 1'b1, la, word_t'($random(seed)), 1'b0, 1'b1);
        access(3'd3, 1'b0, la, '0, 1'b0, 1'b0);
        for (int q = 0; q < 4; q++)
        begin
            set_relock(1'b1, 2'(q));
            access(3'd4, 1'b1, {2'd1, la[11:0]}, word_t'($random(seed)), 1'b0, 1'b0);
            access(3'd4, 1'b0, {2'd3, la[11:0]}, '0, 1'b0, 1'b0);
            set_relock(1'b0, 2'd0);
            access(3'd4, 1'b0, {2'(q > 1 ? 1 : 2), la[11:0]}, '0, 1'b0, 1'b0);
        end
        i_ctrl_model.refresh(1);
        #1;
        check("refresh_row", word_t'(2), word_t'(refresh_row));
        // requests stay off the bus until the refresh cycle is over
        repeat (50) @(posedge core_clk);
        access(3'd0, 1'b0, la, '0, 1'b0, 1'b0);
        repeat (100) @(posedge core_clk);
        i_ctrl_model.refresh(1);
        @(posedge core_clk);
        #1;
        dis_exp = 1'b1;
        check("unit_disabled", word_t'(1), word_t'(unit_disabled));
        access(3'd0, 1'b0, la, '0, 1'b0, 1'b0);
        i_ctrl_model.refresh(1);
        repeat (2000) @(posedge core_clk);
        i_ctrl_model.refresh(1);
        #1;
        check("refresh_row", word_t'(2), word_t'(refresh_row));
        check("unit_disabled", word_t'(1), word_t'(unit_disabled));
        master_clear();
        i_ctrl_model.refresh(55);
        @(posedge core_clk);
        #1;
        check("unit_disabled", word_t'(1), word_t'(unit_disabled));
        finish_test();
    end
endmodule : storage_unit_bench
